// ==== hw/cfb_pkg.sv ====
// constants, types and decode helpers for the filter bank configuration block
// assumes a 100 MHz single clock domain and byte addressing on the register bus
//
// Notes on behaviour
// - every receive mailbox register, the high data words of both receive fifos among them, is read-only.
// - the receive high data word shows message byte four in bits 7:0, then bytes five and six, byte seven in 31:24.
// - bit 0 of the filter control register clear means normal filtering, set means filter init mode.
// - bits 13:8 of filter control give the first bank owned by the second controller, over banks 0 to 27.
// - a start bank of 28 gives every bank to the first controller.
// - a start bank of 0 gives every bank to the second controller.
// - the live bits of filter control change only by software writes, never by hardware.
// - the match mode register holds one bit per bank in 27:0, clear for mask matching, set for list matching.
// - the scale register holds one bit per bank 0 to 27, clear for two 16-bit filters, set for one 32-bit filter.
// - the fifo select register holds one bit per filter in 27:0, clear routing to fifo 0, set to fifo 1.
// - mode, scale and fifo select accept writes only while filter init mode is set.

package cfb_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int NUM_BANKS = 28;
  localparam int NUM_FIFOS = 2;
  localparam int MAILBOX_DEPTH = 3;
  localparam int SLOT_W = 2;
  localparam int START_W = 6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RX0_HIGH = 10'h1bc;
  localparam logic [ADDR_W-1:0] OFS_RX1_HIGH = 10'h1cc;
  localparam logic [ADDR_W-1:0] OFS_FILTER_CONTROL = 10'h200;
  localparam logic [ADDR_W-1:0] OFS_MATCH_MODE = 10'h204;
  localparam logic [ADDR_W-1:0] OFS_SCALE = 10'h20c;
  localparam logic [ADDR_W-1:0] OFS_FIFO_SELECT = 10'h214;

  // reset values
  localparam logic [DATA_W-1:0] RST_FILTER_CONTROL = 32'h2a1c0e01;
  localparam logic [DATA_W-1:0] RST_MATCH_MODE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_SCALE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_FIFO_SELECT = 32'h00000000;

  // field positions and masks
  localparam int POS_INIT_MODE = 0;
  localparam int POS_START_LSB = 8;
  localparam logic [DATA_W-1:0] FILTER_CONTROL_LIVE = 32'h00003f01;
  localparam logic [DATA_W-1:0] BANK_BITS_MASK = 32'h0fffffff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_ANSWER = 2'b10
  } cfb_bus_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_RX0 = 3'b001,
    SEL_RX1 = 3'b010,
    SEL_FILTER_CONTROL = 3'b011,
    SEL_MATCH_MODE = 3'b100,
    SEL_SCALE = 3'b101,
    SEL_FIFO_SELECT = 3'b110
  } cfb_reg_sel_t;

  // byte address to register select, misaligned or unknown gives none
  function automatic cfb_reg_sel_t cfb_decode(input logic [ADDR_W-1:0] addr);
    cfb_reg_sel_t sel;
    case (addr)
      OFS_RX0_HIGH: sel = SEL_RX0;
      OFS_RX1_HIGH: sel = SEL_RX1;
      OFS_FILTER_CONTROL: sel = SEL_FILTER_CONTROL;
      OFS_MATCH_MODE: sel = SEL_MATCH_MODE;
      OFS_SCALE: sel = SEL_SCALE;
      OFS_FIFO_SELECT: sel = SEL_FIFO_SELECT;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : cfb_decode

endpackage : cfb_pkg

// ==== hw/cfb_mailbox_mem.sv ====
// small memory holding the high data words of both receive fifos
// assumes one writer and one reader on the same clock; read data is registered
`timescale 1ns/1ps

module cfb_mailbox_mem #(
  parameter int WIDTH = 32,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // array has no reset: contents are undefined until a frame lands
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : cfb_mailbox_mem

// ==== hw/cfb_filter_bank.sv ====
// register slice of the dual-controller can filter: receive high data words
// and filter configuration, reached over an avalon-mm slave with waitrequest
// assumes the receive engine runs on clk and pushes words itself; no pin inputs
`timescale 1ns/1ps

module cfb_filter_bank #(
  parameter int NUM_BANKS = cfb_pkg::NUM_BANKS,
  parameter int MAILBOX_DEPTH = cfb_pkg::MAILBOX_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [cfb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cfb_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [cfb_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // receive engine side
  input wire logic rx_store_valid,
  input wire logic rx_store_fifo,
  input wire logic [cfb_pkg::DATA_W-1:0] rx_store_data,
  input wire logic [1:0] rx_release,
  output logic [1:0] rx_fifo_full,
  output logic [1:0] rx_fifo_pending,
  // configuration towards the matching logic
  output logic filter_init_mode,
  output logic [cfb_pkg::START_W-1:0] second_ctrl_start_bank,
  output logic [NUM_BANKS-1:0] bank_list_mode_bit,
  output logic [NUM_BANKS-1:0] bank_scale_bit,
  output logic [NUM_BANKS-1:0] bank_fifo_bit,
  output logic [NUM_BANKS-1:0] bank_second_ctrl
);

  localparam logic [1:0] DEPTH_CNT = 2'(MAILBOX_DEPTH);
  localparam logic [1:0] LAST_SLOT = 2'(MAILBOX_DEPTH - 1);

  cfb_pkg::cfb_bus_state_t state;
  cfb_pkg::cfb_reg_sel_t sel;
  cfb_pkg::cfb_reg_sel_t addr_sel;
  logic req_write;
  logic [cfb_pkg::DATA_W-1:0] req_data;
  logic [3:0] req_be;
  logic [1:0] wr_ptr [0:1];
  logic [1:0] rd_ptr [0:1];
  logic [1:0] count [0:1];
  logic [1:0] next_count [0:1];
  logic push_ok;
  logic [2:0] mem_wr_addr;
  logic [2:0] mem_rd_addr;
  logic [cfb_pkg::DATA_W-1:0] mem_rd_data;
  logic [cfb_pkg::DATA_W-1:0] filter_control_rd;
  logic [cfb_pkg::DATA_W-1:0] bank_word_mask;
  logic commit;
  logic commit_bank_reg;
  logic [cfb_pkg::DATA_W-1:0] mode_merged;
  logic [cfb_pkg::DATA_W-1:0] scale_merged;
  logic [cfb_pkg::DATA_W-1:0] fifo_sel_merged;

  // merge enabled byte lanes of new into old
  function automatic logic [31:0] be_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // address decode of the live request
  assign addr_sel = cfb_pkg::cfb_decode(avs_address);
  assign bank_word_mask = cfb_pkg::BANK_BITS_MASK;

  // bank words with the enabled lanes of the pending write folded in
  assign mode_merged = be_merge({4'h0, bank_list_mode_bit}, req_data, req_be);
  assign scale_merged = be_merge({4'h0, bank_scale_bit}, req_data, req_be);
  assign fifo_sel_merged = be_merge({4'h0, bank_fifo_bit}, req_data, req_be);

  // ---------------------------------------------------------------- bus fsm
  // idle -> fetch (mailbox read issued) -> answer (waitrequest low one cycle)
  // every access takes the same path so the answer latency is fixed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cfb_pkg::ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (state)
        cfb_pkg::ST_IDLE: begin
          if (avs_read || avs_write) begin
            state <= cfb_pkg::ST_FETCH;
          end
        end
        cfb_pkg::ST_FETCH: begin
          state <= cfb_pkg::ST_ANSWER;
          avs_waitrequest <= 1'b0;
        end
        cfb_pkg::ST_ANSWER: begin
          // master drops the request at this edge, so idle sees a fresh one
          state <= cfb_pkg::ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state <= cfb_pkg::ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // request capture at acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel <= cfb_pkg::SEL_NONE;
      req_write <= 1'b0;
      req_data <= '0;
      req_be <= 4'h0;
    end else if (state == cfb_pkg::ST_IDLE && (avs_read || avs_write)) begin
      sel <= addr_sel;
      req_write <= avs_write;
      req_data <= avs_writedata;
      req_be <= avs_byteenable;
    end
  end

  // writes land on the fetch -> answer edge
  assign commit = (state == cfb_pkg::ST_FETCH) && req_write;
  // bank registers are frozen outside init mode, the write is simply dropped
  assign commit_bank_reg = commit && filter_init_mode;

  // ---------------------------------------------------------------- filter control
  // only a bus write moves these; nothing in hardware touches them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_init_mode <= cfb_pkg::RST_FILTER_CONTROL[cfb_pkg::POS_INIT_MODE];
      second_ctrl_start_bank <= cfb_pkg::RST_FILTER_CONTROL[cfb_pkg::POS_START_LSB +: cfb_pkg::START_W];
    end else if (commit && sel == cfb_pkg::SEL_FILTER_CONTROL) begin
      if (req_be[0]) begin
        filter_init_mode <= req_data[cfb_pkg::POS_INIT_MODE];
      end
      if (req_be[1]) begin
        second_ctrl_start_bank <= req_data[cfb_pkg::POS_START_LSB +: cfb_pkg::START_W];
      end
    end
  end

  // ---------------------------------------------------------------- bank registers
  // one bit per bank; reserved top nibble never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_list_mode_bit <= cfb_pkg::RST_MATCH_MODE[NUM_BANKS-1:0];
    end else if (commit_bank_reg && sel == cfb_pkg::SEL_MATCH_MODE) begin
      bank_list_mode_bit <= mode_merged[NUM_BANKS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_scale_bit <= cfb_pkg::RST_SCALE[NUM_BANKS-1:0];
    end else if (commit_bank_reg && sel == cfb_pkg::SEL_SCALE) begin
      bank_scale_bit <= scale_merged[NUM_BANKS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_fifo_bit <= cfb_pkg::RST_FIFO_SELECT[NUM_BANKS-1:0];
    end else if (commit_bank_reg && sel == cfb_pkg::SEL_FIFO_SELECT) begin
      bank_fifo_bit <= fifo_sel_merged[NUM_BANKS-1:0];
    end
  end

  // ---------------------------------------------------------------- bank ownership
  // bank i goes to the second controller when i >= start bank; so 0 hands
  // over every bank and 28 or more keeps every bank on the first controller
  generate
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_owner
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bank_second_ctrl[i] <= 1'b0;
        end else begin
          bank_second_ctrl[i] <= (6'(i) >= second_ctrl_start_bank);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------- receive fifos
  // a word arriving while its fifo is full is lost; the engine must watch full
  assign push_ok = rx_store_valid && !rx_fifo_full[rx_store_fifo];
  assign mem_wr_addr = {rx_store_fifo, wr_ptr[rx_store_fifo]};
  assign mem_rd_addr = {(addr_sel == cfb_pkg::SEL_RX1), rd_ptr[addr_sel == cfb_pkg::SEL_RX1]};

  generate
    for (genvar f = 0; f < 2; f++) begin : g_fifo
      logic push_here;
      logic pop_here;
      assign push_here = push_ok && (rx_store_fifo == 1'(f));
      assign pop_here = rx_release[f] && (count[f] != 2'h0);

      always_comb begin
        next_count[f] = count[f];
        if (push_here && !pop_here) begin
          next_count[f] = count[f] + 2'h1;
        end else if (pop_here && !push_here) begin
          next_count[f] = count[f] - 2'h1;
        end
      end

      // pointers wrap at the mailbox depth, not at the power of two
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wr_ptr[f] <= 2'h0;
          rd_ptr[f] <= 2'h0;
          count[f] <= 2'h0;
          rx_fifo_full[f] <= 1'b0;
          rx_fifo_pending[f] <= 1'b0;
        end else begin
          if (push_here) begin
            wr_ptr[f] <= (wr_ptr[f] == LAST_SLOT) ? 2'h0 : wr_ptr[f] + 2'h1;
          end
          if (pop_here) begin
            rd_ptr[f] <= (rd_ptr[f] == LAST_SLOT) ? 2'h0 : rd_ptr[f] + 2'h1;
          end
          count[f] <= next_count[f];
          rx_fifo_full[f] <= (next_count[f] == DEPTH_CNT);
          rx_fifo_pending[f] <= (next_count[f] != 2'h0);
        end
      end
    end
  endgenerate

  // word stored as delivered: byte four low lane up to byte seven high lane
  cfb_mailbox_mem #(
    .WIDTH(cfb_pkg::DATA_W),
    .AW(3)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(push_ok),
    .wr_addr(mem_wr_addr),
    .wr_data(rx_store_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  // ---------------------------------------------------------------- read back
  // reserved control bits read back their fixed reset pattern
  assign filter_control_rd = (cfb_pkg::RST_FILTER_CONTROL & ~cfb_pkg::FILTER_CONTROL_LIVE)
                           | {18'h0, second_ctrl_start_bank, 7'h0, filter_init_mode};

  // read data latched on the fetch -> answer edge and held until next answer;
  // mailbox writes never reach the memory, only the engine pushes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (state == cfb_pkg::ST_FETCH) begin
      if (req_write) begin
        avs_readdata <= '0;
      end else begin
        case (sel)
          cfb_pkg::SEL_RX0: avs_readdata <= (count[0] != 2'h0) ? mem_rd_data : '0;
          cfb_pkg::SEL_RX1: avs_readdata <= (count[1] != 2'h0) ? mem_rd_data : '0;
          cfb_pkg::SEL_FILTER_CONTROL: avs_readdata <= filter_control_rd;
          cfb_pkg::SEL_MATCH_MODE: avs_readdata <= {4'h0, bank_list_mode_bit} & bank_word_mask;
          cfb_pkg::SEL_SCALE: avs_readdata <= {4'h0, bank_scale_bit} & bank_word_mask;
          cfb_pkg::SEL_FIFO_SELECT: avs_readdata <= {4'h0, bank_fifo_bit} & bank_word_mask;
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

endmodule : cfb_filter_bank

// ==== verif/cfb_filter_bank_chk.sv ====
// concurrent checks on the ports of the filter bank configuration block
// assumes one clock and an async active-low reset; bound into every instance
`timescale 1ns/1ps

module cfb_filter_bank_chk #(
  parameter int NUM_BANKS = 28,
  parameter int MAILBOX_DEPTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [cfb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cfb_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [cfb_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_store_valid,
  input wire logic rx_store_fifo,
  input wire logic [cfb_pkg::DATA_W-1:0] rx_store_data,
  input wire logic [1:0] rx_release,
  input wire logic [1:0] rx_fifo_full,
  input wire logic [1:0] rx_fifo_pending,
  input wire logic filter_init_mode,
  input wire logic [cfb_pkg::START_W-1:0] second_ctrl_start_bank,
  input wire logic [NUM_BANKS-1:0] bank_list_mode_bit,
  input wire logic [NUM_BANKS-1:0] bank_scale_bit,
  input wire logic [NUM_BANKS-1:0] bank_fifo_bit,
  input wire logic [NUM_BANKS-1:0] bank_second_ctrl
);
  logic [NUM_BANKS-1:0] exp_second;
  logic wr_ack;

  // ownership mask; start banks past 28 leave the second controller nothing
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      exp_second[i] = (second_ctrl_start_bank <= 6'd28) && (i >= int'(second_ctrl_start_bank));
    end
  end
  assign wr_ack = avs_write && !avs_waitrequest; // write lands as the answer shows

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_init_mode_sw: assert property (
    $changed(filter_init_mode) |-> wr_ack && avs_address == 10'h200 && avs_byteenable[0])
    else $error("init mode changed without a control write");
  a_start_bank_sw: assert property (
    $changed(second_ctrl_start_bank) |-> wr_ack && avs_address == 10'h200 && avs_byteenable[1])
    else $error("start bank changed without a control write");
  a_mode_gated: assert property (
    $changed(bank_list_mode_bit) |-> wr_ack && avs_address == 10'h204 && $past(filter_init_mode))
    else $error("match mode changed outside init mode write");
  a_scale_gated: assert property (
    $changed(bank_scale_bit) |-> wr_ack && avs_address == 10'h20c && $past(filter_init_mode))
    else $error("scale changed outside init mode write");
  a_fifo_sel_gated: assert property (
    $changed(bank_fifo_bit) |-> wr_ack && avs_address == 10'h214 && $past(filter_init_mode))
    else $error("fifo select changed outside init mode write");
  a_bank_owner_map: assert property (
    $past(rst_n) |-> bank_second_ctrl == $past(exp_second))
    else $error("bank ownership does not follow start bank");
  a_answer_timing: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not two cycles after request");
  a_wait_one_cycle: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_mode_readback: assert property (
    avs_read && !avs_waitrequest && avs_address == 10'h204 |-> avs_readdata == 32'(bank_list_mode_bit))
    else $error("match mode read differs from port");
endmodule : cfb_filter_bank_chk

bind cfb_filter_bank cfb_filter_bank_chk #(.NUM_BANKS(NUM_BANKS), .MAILBOX_DEPTH(MAILBOX_DEPTH)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_store_valid(rx_store_valid), .rx_store_fifo(rx_store_fifo),
  .rx_store_data(rx_store_data), .rx_release(rx_release), .rx_fifo_full(rx_fifo_full),
  .rx_fifo_pending(rx_fifo_pending), .filter_init_mode(filter_init_mode),
  .second_ctrl_start_bank(second_ctrl_start_bank), .bank_list_mode_bit(bank_list_mode_bit),
  .bank_scale_bit(bank_scale_bit), .bank_fifo_bit(bank_fifo_bit), .bank_second_ctrl(bank_second_ctrl));

// ==== verif/tb_top.sv ====
// self-checking bench for the filter bank configuration block
// assumes the bus answers by waitrequest low; bench plays bus master and receive engine
`timescale 1ns/1ps

module tb_top;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, rx_store_valid, rx_store_fifo, filter_init_mode;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rx_store_data;
  logic [3:0] avs_byteenable;
  logic [1:0] rx_release, rx_fifo_full, rx_fifo_pending;
  logic [5:0] second_ctrl_start_bank;
  logic [27:0] bank_list_mode_bit, bank_scale_bit, bank_fifo_bit, bank_second_ctrl;
  int failures = 0;
  int samples_checked = 0;

  cfb_filter_bank dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_store_valid(rx_store_valid), .rx_store_fifo(rx_store_fifo),
    .rx_store_data(rx_store_data), .rx_release(rx_release), .rx_fifo_full(rx_fifo_full),
    .rx_fifo_pending(rx_fifo_pending), .filter_init_mode(filter_init_mode),
    .second_ctrl_start_bank(second_ctrl_start_bank), .bank_list_mode_bit(bank_list_mode_bit),
    .bank_scale_bit(bank_scale_bit), .bank_fifo_bit(bank_fifo_bit), .bank_second_ctrl(bank_second_ctrl));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_port(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: port shows %h, expected %h", $time, got, exp);
    end
  endtask : check_port

  // one avalon-mm access; request stands until the rising edge that sees waitrequest low
  task automatic bus(input logic is_write, input logic [9:0] addr, input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rdata);
    @(posedge clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !is_write;
    avs_write <= is_write;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] addr, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] unused;
    bus(1'b1, addr, wd, be, unused);
  endtask : wr

  task automatic rd_chk(input logic [9:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, addr, 32'h0, 4'hf, got);
    check_reg(got, exp);
  endtask : rd_chk

  // receive engine strobes, one cycle each
  task automatic rx_push(input logic f, input logic [31:0] d);
    @(posedge clk);
    rx_store_valid <= 1'b1;
    rx_store_fifo <= f;
    rx_store_data <= d;
    @(posedge clk);
    rx_store_valid <= 1'b0;
    @(posedge clk); // flags move on the push edge, look one edge later
  endtask : rx_push

  task automatic rx_pop(input logic [1:0] f);
    @(posedge clk);
    rx_release <= f;
    @(posedge clk);
    rx_release <= 2'b00;
  endtask : rx_pop

  task automatic test_reset;
    check_port(32'(filter_init_mode), 32'h1);
    check_port(32'(second_ctrl_start_bank), 32'h0e);
    check_port(32'(bank_second_ctrl), 32'h0fffc000);
    rd_chk(10'h200, 32'h2a1c0e01);
    rd_chk(10'h204, 32'h0);
    rd_chk(10'h20c, 32'h0);
    rd_chk(10'h214, 32'h0);
    rd_chk(10'h1bc, 32'h0);
    rd_chk(10'h208, 32'h0);
  endtask : test_reset

  task automatic test_config_gate;
    logic [9:0] ofs [3] = '{10'h204, 10'h20c, 10'h214};
    for (int k = 0; k < 3; k++) begin
      wr(ofs[k], 32'hffffffff, 4'hf);
      rd_chk(ofs[k], 32'h0fffffff);
    end
    check_port(32'(bank_list_mode_bit & bank_scale_bit & bank_fifo_bit), 32'h0fffffff);
    wr(10'h200, 32'h00000e00, 4'h1);
    check_port(32'(filter_init_mode), 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ofs[k], 32'h0, 4'hf);
      rd_chk(ofs[k], 32'h0fffffff);
    end
    wr(10'h200, 32'h00000001, 4'h1);
    for (int k = 0; k < 3; k++) begin
      wr(ofs[k], 32'h05a5a5a5, 4'h5);
      rd_chk(ofs[k], 32'h0fa5ffa5);
    end
    check_port(32'(bank_scale_bit ^ bank_fifo_bit), 32'h0);
  endtask : test_config_gate

  task automatic test_start_bank;
    logic [5:0] sb [5] = '{6'd0, 6'd1, 6'd13, 6'd27, 6'd28};
    for (int k = 0; k < 5; k++) begin
      wr(10'h200, {18'h0, sb[k], 8'h00}, 4'h2);
      @(posedge clk); // ownership lags the field by a cycle
      check_port(32'(bank_second_ctrl), 32'h0fffffff & (32'hffffffff << sb[k]));
      rd_chk(10'h200, 32'h2a1c0001 | (32'(sb[k]) << 8));
    end
    rx_push(1'b0, 32'h01020304);
    rx_pop(2'b01);
    repeat (20) @(posedge clk);
    check_port({25'h0, second_ctrl_start_bank, filter_init_mode}, {25'h0, 6'd28, 1'b1});
  endtask : test_start_bank

  task automatic test_rx;
    rx_push(1'b0, 32'h77665544);
    rx_push(1'b1, 32'hfedcba98);
    check_port(32'(rx_fifo_pending), 32'h3);
    rd_chk(10'h1bc, 32'h77665544);
    rd_chk(10'h1cc, 32'hfedcba98);
    wr(10'h1bc, 32'h0, 4'hf);
    wr(10'h1cc, 32'h12345678, 4'hf);
    rd_chk(10'h1bc, 32'h77665544);
    rd_chk(10'h1cc, 32'hfedcba98);
    rx_push(1'b0, 32'h0b0a0908);
    rx_push(1'b0, 32'h0f0e0d0c);
    check_port(32'(rx_fifo_full), 32'h1);
    rx_pop(2'b11);
    rd_chk(10'h1bc, 32'h0b0a0908);
    rd_chk(10'h1cc, 32'h0);
  endtask : test_rx

  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    rx_store_valid = 1'b0;
    rx_store_fifo = 1'b0;
    rx_store_data = 32'h0;
    rx_release = 2'b00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset();
    test_config_gate();
    test_start_bank();
    test_rx();
    finish_test();
  end

  // a hung handshake would otherwise never end the run
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule : tb_top
